// ==== hw/sfac_backoff.sv ====
// Collision backoff slot generator with standard and aggressive modes.
`timescale 1ns/1ps
module sfac_backoff
   import sfac_pkg::*;
(
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic [sfac_pkg::COL_W-1:0]  col_count,
   input  wire logic                        aggressive,
   output logic [sfac_pkg::SLOT_W-1:0]      slots
);

   logic [SLOT_W-1:0] lfsr;
   logic [3:0]        cap;
   logic [3:0]        expo;
   logic [SLOT_W-1:0] mask;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lfsr <= LFSR_SEED;
      end else begin
         lfsr <= {lfsr[SLOT_W-2:0], lfsr[9] ^ lfsr[6]};
      end
   end

   // The aggressive cap keeps the window small so a port retries sooner.
   assign cap  = aggressive ? EXP_AGGRESSIVE : EXP_STANDARD; // R1
   assign expo = ({1'b0, cap} < col_count) ? cap : col_count[3:0];

   always_comb begin
      mask = '0;
      for (int i = 0; i < SLOT_W; i++) begin
         mask[i] = (4'(i) < expo);
      end
   end

   assign slots = lfsr & mask;

endmodule : sfac_backoff

// ==== hw/sfac_len_check.sv ====
// Maximum frame length selection and length comparison.
`timescale 1ns/1ps
module sfac_len_check
   import sfac_pkg::*;
(
   input  wire logic [sfac_pkg::LEN_W-1:0]  frame_len,
   input  wire logic                        frame_tagged,
   input  wire logic                        cpu_special_tag,
   input  wire logic [sfac_pkg::PORT_W-1:0] dest_port,
   input  wire logic                        jumbo_en,
   input  wire logic                        size_chk_dis,
   output logic                             len_ok
);

   logic [LEN_W-1:0] limit;
   logic             to_user_port;
   logic             tag_exempt;

   assign to_user_port = (dest_port >= PORT_FIRST_USER) &&
                         (dest_port <= PORT_LAST_USER);
   // Frames from the CPU with the special tag, bound for user ports 1 to 4, skip the tagged ceiling.
   assign tag_exempt   = frame_tagged && cpu_special_tag && to_user_port; // R10

   always_comb begin
      if (jumbo_en) begin
         limit = LEN_JUMBO; // R8
      end else if (size_chk_dis) begin
         limit = LEN_SIZE_CHK_OFF; // R9
      end else if (frame_tagged) begin
         limit = LEN_TAGGED; // R10
      end else begin
         limit = LEN_UNTAGGED; // R10
      end
   end

   // The special tag lifts only the tagged ceiling; the jumbo and the
   // size-check-off ceilings still bind such frames.
   assign len_ok = (tag_exempt && !jumbo_en && !size_chk_dis) ||
                   (frame_len <= limit); // R9 R10

endmodule : sfac_len_check

// ==== hw/sfac_pkg.sv ====
// Constants shared by the frame admission control block.
package sfac_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam int          ADDR_W            = 8;
   localparam int          DATA_W            = 8;
   localparam logic [7:0]  ADDR_GLOBAL_CTRL1 = 8'h03;
   localparam logic [7:0]  ADDR_FRAME_POLICY = 8'h04;
   localparam logic [7:0]  ADDR_DROP_COUNT   = 8'h10;
   localparam logic [7:0]  ADDR_STORM_COUNT  = 8'h11;
   localparam logic [7:0]  ADDR_COL_COUNT    = 8'h12;

   // Field positions.
   localparam int          BIT_AGGR_BACKOFF  = 0;
   localparam int          BIT_RSVD7         = 7;
   localparam int          BIT_MCAST_EXCL    = 6;
   localparam int          BIT_RSVD5         = 5;
   localparam int          BIT_FAIR_MODE     = 4;
   localparam int          BIT_KEEP_EXCOL    = 3;
   localparam int          BIT_JUMBO         = 2;
   localparam int          BIT_SIZE_CHK_DIS  = 1;

   // Reset values of the non-strapped bits.
   localparam logic        RST_RSVD7         = 1'b1;
   localparam logic        RST_MCAST_EXCL    = 1'b1;
   localparam logic        RST_RSVD5         = 1'b1;
   localparam logic        RST_FAIR_MODE     = 1'b1;
   localparam logic        RST_JUMBO         = 1'b0;

   // ------------------------------------------------------------------
   // Frame sizes and collision figures
   // ------------------------------------------------------------------
   localparam int          LEN_W             = 11;
   localparam logic [10:0] LEN_JUMBO         = 11'h77C;
   localparam logic [10:0] LEN_SIZE_CHK_OFF  = 11'h600;
   localparam logic [10:0] LEN_UNTAGGED      = 11'h5EE;
   localparam logic [10:0] LEN_TAGGED        = 11'h5F2;
   localparam int          PORT_W            = 3;
   localparam logic [2:0]  PORT_FIRST_USER   = 3'h1;
   localparam logic [2:0]  PORT_LAST_USER    = 3'h4;
   localparam int          COL_W             = 5;
   localparam logic [4:0]  COL_EXCESSIVE     = 5'h10;
   localparam logic [3:0]  EXP_STANDARD      = 4'hA;
   localparam logic [3:0]  EXP_AGGRESSIVE    = 4'h3;
   localparam int          SLOT_W            = 10;
   localparam logic [9:0]  LFSR_SEED         = 10'h2A5;
   localparam logic [47:0] DA_BROADCAST      = 48'hFFFF_FFFF_FFFF;
   localparam int          DA_GROUP_BIT      = 40;

endpackage : sfac_pkg

// ==== hw/sfac_top.sv ====
// Global frame admission controls: registers and admission decisions.
//
// What this block does
// R1: Aggressive backoff bit shortens half-duplex collision backoff windows.
// R2: Aggressive backoff bit resets from backoff strap pin, default off.
// R3: Multicast exclusion set counts broadcast only; clear adds group bit.
// R4: Fair mode set drops non-flow-controlled frames sharing destination.
// R5: Fair mode clear flow-controls the flow-controlled source instead.
// R6: Clear keep bit drops frames at 16 collisions; set keeps them.
// R7: Keep bit resets from collision strap pin, default drop.
// R8: Jumbo bit admits up to 1916 bytes, overriding size check.
// R9: Size check disabled admits up to 1536 bytes, drops longer.
// R10: Otherwise 1518 untagged, 1522 tagged; CPU special tag exempt.
// R11: Size check disable bit resets from frame size strap pin.
// R12: Software writes ones back into reserved bits seven and five.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module sfac_top
   import sfac_pkg::*;
(
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic [sfac_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [sfac_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [sfac_pkg::DATA_W-1:0]   reg_rdata,
   input  wire logic                          backoff_strap_pin,
   input  wire logic                          collision_drop_strap_pin,
   input  wire logic                          frame_size_strap_pin,
   input  wire logic                          frm_valid,
   input  wire logic [sfac_pkg::LEN_W-1:0]    frm_len,
   input  wire logic                          frm_tagged,
   input  wire logic                          cpu_special_tag,
   input  wire logic [sfac_pkg::PORT_W-1:0]   frm_dest_port,
   output logic                               frm_done,
   output logic                               frm_accept,
   input  wire logic                          da_valid,
   input  wire logic [47:0]                   da,
   output logic                               storm_count,
   input  wire logic                          col_valid,
   input  wire logic [sfac_pkg::COL_W-1:0]    col_count,
   input  wire logic                          col_half_duplex,
   output logic                               col_done,
   output logic                               col_retry,
   output logic                               col_drop,
   output logic      [sfac_pkg::SLOT_W-1:0]   backoff_slots,
   input  wire logic                          share_valid,
   output logic                               drop_nonfc,
   output logic                               pause_fc,
   output logic                               aggr_backoff,
   output logic                               mcast_excl,
   output logic                               fair_mode,
   output logic                               keep_excol,
   output logic                               jumbo_en,
   output logic                               size_chk_dis
);
   import sfac_pkg::*;

   // ------------------------------------------------------------------
   // Internal signals
   // ------------------------------------------------------------------
   logic                rsvd7;
   logic                rsvd5;
   logic                wr_ctrl1;
   logic                wr_policy;
   logic                len_ok;
   logic                is_bcast;
   logic                is_group;
   logic                excessive;
   logic [SLOT_W-1:0]   slots;
   logic [DATA_W-1:0]   drop_cnt;
   logic [DATA_W-1:0]   storm_cnt;
   logic [DATA_W-1:0]   excol_cnt;
   logic [DATA_W-1:0]   next_rdata;
   logic                frame_drop;

   assign wr_ctrl1  = reg_wr && (reg_addr == ADDR_GLOBAL_CTRL1);
   assign wr_policy = reg_wr && (reg_addr == ADDR_FRAME_POLICY);

   // ------------------------------------------------------------------
   // Global control 1, aggressive backoff bit only
   // ------------------------------------------------------------------
   // Reset is synchronous, so the strap is caught on the clock edge that
   // sees rst_n low; the pin must be stable for that edge.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         aggr_backoff <= backoff_strap_pin; // R2
      end else if (wr_ctrl1) begin
         aggr_backoff <= reg_wdata[BIT_AGGR_BACKOFF];
      end
   end

   // ------------------------------------------------------------------
   // Frame policy register
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rsvd7        <= RST_RSVD7;
         mcast_excl   <= RST_MCAST_EXCL; // R3
         rsvd5        <= RST_RSVD5;
         fair_mode    <= RST_FAIR_MODE; // R4
         keep_excol   <= collision_drop_strap_pin; // R7
         jumbo_en     <= RST_JUMBO; // R8
         size_chk_dis <= frame_size_strap_pin; // R11
      end else if (wr_policy) begin
         // Reserved bits store what software writes; it must write ones.
         rsvd7        <= reg_wdata[BIT_RSVD7]; // R12
         mcast_excl   <= reg_wdata[BIT_MCAST_EXCL];
         rsvd5        <= reg_wdata[BIT_RSVD5]; // R12
         fair_mode    <= reg_wdata[BIT_FAIR_MODE];
         keep_excol   <= reg_wdata[BIT_KEEP_EXCOL];
         jumbo_en     <= reg_wdata[BIT_JUMBO];
         size_chk_dis <= reg_wdata[BIT_SIZE_CHK_DIS];
      end
   end

   // ------------------------------------------------------------------
   // Register read path
   // ------------------------------------------------------------------
   always_comb begin
      next_rdata = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_GLOBAL_CTRL1: begin
               next_rdata[BIT_AGGR_BACKOFF] = aggr_backoff;
            end
            ADDR_FRAME_POLICY: begin
               next_rdata[BIT_RSVD7]        = rsvd7;
               next_rdata[BIT_MCAST_EXCL]   = mcast_excl;
               next_rdata[BIT_RSVD5]        = rsvd5;
               next_rdata[BIT_FAIR_MODE]    = fair_mode;
               next_rdata[BIT_KEEP_EXCOL]   = keep_excol;
               next_rdata[BIT_JUMBO]        = jumbo_en;
               next_rdata[BIT_SIZE_CHK_DIS] = size_chk_dis;
            end
            ADDR_DROP_COUNT: begin
               next_rdata = drop_cnt;
            end
            ADDR_STORM_COUNT: begin
               next_rdata = storm_cnt;
            end
            ADDR_COL_COUNT: begin
               next_rdata = excol_cnt;
            end
            default: begin
               next_rdata = '0;
            end
         endcase
      end
   end

   // Data stand only in the cycle after the read strobe, zero otherwise.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // ------------------------------------------------------------------
   // Frame length admission
   // ------------------------------------------------------------------
   sfac_len_check u_len_check (
      .frame_len       (frm_len),
      .frame_tagged    (frm_tagged),
      .cpu_special_tag (cpu_special_tag),
      .dest_port       (frm_dest_port),
      .jumbo_en        (jumbo_en),
      .size_chk_dis    (size_chk_dis),
      .len_ok          (len_ok)
   );

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         frm_done   <= 1'b0;
         frm_accept <= 1'b0;
      end else begin
         frm_done   <= frm_valid;
         frm_accept <= frm_valid && len_ok; // R8 R9 R10
      end
   end

   assign frame_drop = frm_valid && !len_ok;

   // Saturating so a flood of bad frames cannot wrap to a small count.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         drop_cnt <= '0;
      end else if (frame_drop && (drop_cnt != '1)) begin
         drop_cnt <= drop_cnt + 8'h01;
      end
   end

   // ------------------------------------------------------------------
   // Broadcast storm classification
   // ------------------------------------------------------------------
   assign is_bcast = (da == DA_BROADCAST);
   assign is_group = da[DA_GROUP_BIT];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         storm_count <= 1'b0;
      end else begin
         storm_count <= da_valid &&
                        (is_bcast || (!mcast_excl && is_group)); // R3
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         storm_cnt <= '0;
      end else if (storm_count && (storm_cnt != '1)) begin
         storm_cnt <= storm_cnt + 8'h01;
      end
   end

   // ------------------------------------------------------------------
   // Collision handling and backoff
   // ------------------------------------------------------------------
   // Full-duplex ports never collide, so the aggressive mode is gated by
   // the half-duplex indication of the reporting port.
   sfac_backoff u_backoff (
      .clk        (clk),
      .rst_n      (rst_n),
      .col_count  (col_count),
      .aggressive (aggr_backoff && col_half_duplex),
      .slots      (slots)
   );

   assign excessive = (col_count >= COL_EXCESSIVE);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         col_done      <= 1'b0;
         col_retry     <= 1'b0;
         col_drop      <= 1'b0;
         backoff_slots <= '0;
      end else begin
         col_done      <= col_valid;
         col_drop      <= col_valid && excessive && !keep_excol; // R6
         col_retry     <= col_valid && (!excessive || keep_excol); // R6
         backoff_slots <= col_valid ? slots : '0; // R1
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         excol_cnt <= '0;
      end else if (col_valid && excessive && !keep_excol &&
                   (excol_cnt != '1)) begin
         excol_cnt <= excol_cnt + 8'h01;
      end
   end

   // ------------------------------------------------------------------
   // Flow control fairness
   // ------------------------------------------------------------------
   // share_valid marks a flow-controlled and a non-flow-controlled port
   // contending for one destination. Exactly one remedy is chosen.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         drop_nonfc <= 1'b0;
         pause_fc   <= 1'b0;
      end else begin
         drop_nonfc <= share_valid && fair_mode; // R4
         pause_fc   <= share_valid && !fair_mode; // R5
      end
   end

endmodule : sfac_top

// ==== tb/sfac_chk.sv ====
// Concurrent checks on the ports of the frame admission control block.
`timescale 1ns/1ps
module sfac_chk
   import sfac_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        backoff_strap_pin,
   input wire logic        collision_drop_strap_pin,
   input wire logic        frame_size_strap_pin,
   input wire logic        frm_valid,
   input wire logic [10:0] frm_len,
   input wire logic        frm_tagged,
   input wire logic        cpu_special_tag,
   input wire logic [2:0]  frm_dest_port,
   input wire logic        frm_done,
   input wire logic        frm_accept,
   input wire logic        da_valid,
   input wire logic [47:0] da,
   input wire logic        storm_count,
   input wire logic        col_valid,
   input wire logic [4:0]  col_count,
   input wire logic        col_half_duplex,
   input wire logic        col_done,
   input wire logic        col_retry,
   input wire logic        col_drop,
   input wire logic [9:0]  backoff_slots,
   input wire logic        share_valid,
   input wire logic        drop_nonfc,
   input wire logic        pause_fc,
   input wire logic        aggr_backoff,
   input wire logic        mcast_excl,
   input wire logic        fair_mode,
   input wire logic        keep_excol,
   input wire logic        jumbo_en,
   input wire logic        size_chk_dis
);
   logic exempt;
   assign exempt = frm_tagged && cpu_special_tag &&
      frm_dest_port >= PORT_FIRST_USER && frm_dest_port <= PORT_LAST_USER;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_strap;
      $rose(rst_n) |-> aggr_backoff == $past(backoff_strap_pin) &&
         keep_excol == $past(collision_drop_strap_pin) &&
         size_chk_dis == $past(frame_size_strap_pin) && !jumbo_en;
   endproperty
   a_strap: assert property (p_strap) else $error("bad reset value");
   property p_jumbo;
      frm_valid && jumbo_en |=> frm_done &&
         frm_accept == ($past(frm_len) <= LEN_JUMBO);
   endproperty
   a_jumbo: assert property (p_jumbo) else $error("jumbo limit");
   property p_sizeoff;
      frm_valid && !jumbo_en && size_chk_dis |=> frm_done &&
         frm_accept == ($past(frm_len) <= LEN_SIZE_CHK_OFF);
   endproperty
   a_sizeoff: assert property (p_sizeoff) else $error("1536 limit");
   property p_std;
      frm_valid && !jumbo_en && !size_chk_dis && !exempt |=> frm_accept ==
         ($past(frm_len) <= ($past(frm_tagged) ? LEN_TAGGED : LEN_UNTAGGED));
   endproperty
   a_std: assert property (p_std) else $error("standard limit");
   property p_exempt;
      frm_valid && exempt && !jumbo_en && !size_chk_dis |=>
         frm_done && frm_accept;
   endproperty
   a_exempt: assert property (p_exempt) else $error("tag exemption");
   property p_storm;
      da_valid |=> storm_count == ($past(da) == DA_BROADCAST ||
         ($past(da[DA_GROUP_BIT]) && !$past(mcast_excl)));
   endproperty
   a_storm: assert property (p_storm) else $error("storm count");
   property p_fair;
      share_valid |=> drop_nonfc == $past(fair_mode) && pause_fc != drop_nonfc;
   endproperty
   a_fair: assert property (p_fair) else $error("fair mode");
   property p_col;
      col_valid |=> col_done && col_retry != col_drop && col_drop ==
         ($past(col_count) >= COL_EXCESSIVE && !$past(keep_excol));
   endproperty
   a_col: assert property (p_col) else $error("collision drop");
   property p_aggr;
      col_valid && aggr_backoff && col_half_duplex |=> backoff_slots < 10'h8;
   endproperty
   a_aggr: assert property (p_aggr) else $error("aggressive slots");
endmodule : sfac_chk

bind sfac_top sfac_chk i_chk (.*);

// ==== tb/sfac_top_tb.sv ====
// Self-checking testbench of the frame admission control block.
`timescale 1ns/1ps
module sfac_top_tb;
   import sfac_pkg::*;
   logic clk, rst_n, reg_wr, reg_rd, frm_valid, frm_tagged, cpu_special_tag;
   logic da_valid, col_valid, col_half_duplex, share_valid, frm_done;
   logic frm_accept, storm_count, col_done, col_retry, col_drop, drop_nonfc;
   logic pause_fc, aggr_backoff, mcast_excl, fair_mode, keep_excol, jumbo_en;
   logic size_chk_dis, backoff_strap_pin, collision_drop_strap_pin, aggr;
   logic frame_size_strap_pin;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, pol, rdv;
   logic [7:0]  n_drop, n_storm, n_excol;
   logic [10:0] frm_len;
   logic [2:0]  frm_dest_port, st;
   logic [47:0] da;
   logic [4:0]  col_count;
   logic [9:0]  backoff_slots;
   int          seed, failures, compares;
   logic [10:0] lens [10] = '{11'h5EE, 11'h5EF, 11'h5F2, 11'h5F3, 11'h600,
                              11'h601, 11'h77C, 11'h77D, 11'h7FF, 11'h040};
   logic [4:0]  cnts [4] = '{5'h0F, 5'h10, 5'h1F, 5'h03};

   sfac_top i_dut (.*);

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic test_done;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done

   // A stuck run is cut short here and counted as a mismatch.
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      test_done();
   end

   task automatic chk(input string what, input logic [47:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      rdv = reg_rdata;
   endtask : rd

   task automatic regs;
      rd(ADDR_FRAME_POLICY);
      chk("policy", rdv, pol);
      rd(ADDR_GLOBAL_CTRL1);
      chk("ctrl1", rdv, {7'h0, aggr});
      rd(ADDR_DROP_COUNT);
      chk("drops", rdv, n_drop);
      rd(ADDR_STORM_COUNT);
      chk("storms", rdv, n_storm);
      rd(ADDR_COL_COUNT);
      chk("excol", rdv, n_excol);
      chk("mirror", {aggr_backoff, mcast_excl, fair_mode, keep_excol,
          jumbo_en, size_chk_dis}, {aggr, pol[6], pol[4:1]});
   endtask : regs

   // Bits 7 and 5 always go back as ones, as software is expected to do.
   task automatic cfg(input logic [7:0] p);
      pol = {1'b1, p[6], 1'b1, p[4:1], 1'b0};
      aggr = 1'($random(seed));
      wr(ADDR_FRAME_POLICY, pol);
      wr(ADDR_GLOBAL_CTRL1, {7'h0, aggr});
      regs();
   endtask : cfg

   function automatic logic exp_acc(input logic [10:0] len,
                                    input logic tg, cp, input logic [2:0] dp);
      logic [10:0] lim;
      lim = tg ? LEN_TAGGED : LEN_UNTAGGED;
      if (pol[BIT_SIZE_CHK_DIS]) lim = LEN_SIZE_CHK_OFF;
      if (pol[BIT_JUMBO]) lim = LEN_JUMBO;
      return (tg && cp && dp >= 3'h1 && dp <= 3'h4 &&
              !pol[BIT_JUMBO] && !pol[BIT_SIZE_CHK_DIS]) || len <= lim;
   endfunction : exp_acc

   // All four request kinds share one cycle; they are independent paths.
   task automatic shot(input logic [10:0] len, input logic [4:0] cnt);
      logic [2:0]  dp;
      logic [47:0] a;
      logic [3:0]  n;
      logic        tg, cp, half, acc, sto, xd;
      tg = 1'($random(seed));
      cp = 1'($random(seed));
      half = 1'($random(seed));
      dp = 3'($random(seed));
      a = {16'($random(seed)), 32'($random(seed))};
      if (2'($random(seed)) == 2'h0) a = DA_BROADCAST;
      n = (aggr && half) ? 4'h3 : 4'hA;
      if (cnt < 5'(n)) n = 4'(cnt);
      acc = exp_acc(len, tg, cp, dp);
      sto = a == DA_BROADCAST || (a[DA_GROUP_BIT] && !pol[BIT_MCAST_EXCL]);
      xd = cnt >= COL_EXCESSIVE && !pol[BIT_KEEP_EXCOL];
      @(posedge clk);
      frm_valid <= 1'b1;
      frm_len <= len;
      frm_tagged <= tg;
      cpu_special_tag <= cp;
      frm_dest_port <= dp;
      da_valid <= 1'b1;
      da <= a;
      col_valid <= 1'b1;
      col_count <= cnt;
      col_half_duplex <= half;
      share_valid <= 1'b1;
      @(posedge clk);
      frm_valid <= 1'b0;
      da_valid <= 1'b0;
      col_valid <= 1'b0;
      share_valid <= 1'b0;
      #1;
      chk("accept", frm_accept, acc);
      chk("done", {frm_done, col_done}, 2'h3);
      chk("storm", storm_count, sto);
      chk("coll", {col_drop, col_retry}, xd ? 2'h2 : 2'h1);
      chk("slots", backoff_slots >> n, 10'h0);
      chk("fair", {drop_nonfc, pause_fc},
          pol[BIT_FAIR_MODE] ? 2'h2 : 2'h1);
      // The counters saturate, so the model stops at all ones as well.
      if (!acc && n_drop != 8'hFF) n_drop = n_drop + 8'h01;
      if (sto && n_storm != 8'hFF) n_storm = n_storm + 8'h01;
      if (xd && n_excol != 8'hFF) n_excol = n_excol + 8'h01;
   endtask : shot

   initial begin
      seed = 32'hF39D;
      {rst_n, reg_wr, reg_rd, frm_valid, frm_tagged, cpu_special_tag} = '0;
      {da_valid, col_valid, col_half_duplex, share_valid} = '0;
      {backoff_strap_pin, collision_drop_strap_pin, frame_size_strap_pin} = '0;
      {reg_addr, reg_wdata, frm_len, frm_dest_port, da, col_count} = '0;
      st = 3'($random(seed));
      for (int r = 0; r < 2; r++) begin
         @(posedge clk);
         rst_n <= 1'b0;
         {backoff_strap_pin, collision_drop_strap_pin,
          frame_size_strap_pin} <= (r == 0) ? st : ~st;
         repeat (20) @(posedge clk);
         rst_n <= 1'b1;
         pol = {4'hF, collision_drop_strap_pin, 1'b0, frame_size_strap_pin,
                1'b0};
         aggr = backoff_strap_pin;
         {n_drop, n_storm, n_excol} = '0;
         regs();
         $display("test reset %0d done", r);
         for (int c = 0; c < 4; c++) begin
            cfg({5'($random(seed)), 2'(c), 1'b0});
            foreach (lens[i]) shot(lens[i], cnts[i % 4]);
         end
         $display("test size limits done");
         for (int i = 0; i < 300; i++) begin
            if (i % 25 == 0) cfg(8'($random(seed)));
            shot(11'($random(seed)), 5'($random(seed)));
         end
         $display("test random traffic done");
         rd(8'h20);
         chk("unmapped", rdv, 8'h0);
         wr(8'h21, 8'hFF);
         regs();
         $display("test unmapped done");
      end
      test_done();
   end
endmodule : sfac_top_tb
